// ===== logic/sgss_switcher.sv
// Servo gain set switcher: two gain sets, manual or automatic selection with wait and ramp.
//
// Operation
// R01: Method digit 0 means manual switching, 2 means automatic, effective immediately.
// R02: Software must not program method value 1; it is reserved.
// R03: Two seven-gain sets are stored; loops see only the applied set.
// R04: Model-following pair switches only in manual mode; automatic keeps set 1 values.
// R05: Model-following pair switches only with request, no command, and motor stopped.
// R06: If moving or busy, other gains switch while the model-following pair holds.
// R07: Manual select bit 0 applies set 1, bit 1 applies set 2.
// R08: Automatic conditions are evaluated only in position control.
// R09: Condition A true moves to set 2 with first wait and ramp times.
// R10: Condition A false moves back to set 1 with second wait and ramp times.
// R11: Condition codes 0 to 5 decode done, near and reference signals on or off.
// R12: Outside position control, codes 0,2,4 hold set 1; codes 1,3,5 hold set 2.
// R13: Transition starts only after the applicable waiting time elapses.
// R14: Gains move linearly and finish within the applicable switching time.
// R15: Automatic switching works for both speed control structures.
// R16: Wait and ramp times are 0 to 65535 ms steps, reset value 0.
// R17: Monitor reads 1 while set 1 is active and 2 while set 2 is active.
// R18: Zero ramp time applies the new set in one cycle after the wait.
// R19: A reversal mid-wait or mid-ramp restarts timing from the applied gains.
`timescale 1ns/1ps
`include "sgss_params.svh"
module sgss_switcher
	import sgss_pkg::*;
#(
	parameter int MS_CYCLES = `SGSS_MS_CYCLES,
	parameter int GAINS = 7
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire sgss_bus_s bus,
	output logic [15:0] rdata,
	input wire logic gainSelect,
	input wire logic speedStructIp,
	input wire sgss_status_s statusPins,
	output logic [16*GAINS-1:0] appliedGains,
	output logic [1:0] activeGainSetMonitor
);
	logic [15:0] gainSwitchConfig_reg;
	logic [15:0] setA_reg [GAINS];
	logic [15:0] setB_reg [GAINS];
	logic [15:0] waitTimeUp_reg;
	logic [15:0] waitTimeDown_reg;
	logic [15:0] rampTimeUp_reg;
	logic [15:0] rampTimeDown_reg;
	sgss_status_s sync1_reg;
	sgss_status_s sync2_reg;
	logic gsel1_reg;
	logic gsel2_reg;
	sgss_state_e state_reg;
	logic wantSet2;
	logic target2_reg;
	logic applied2_reg;
	logic mfApplied2_reg;
	logic [31:0] msDiv_reg;
	logic msTick;
	logic [15:0] msCount_reg;
	logic [15:0] rampLen_reg;
	logic startRamp;
	logic jumpNow;
	logic stepNow;
	logic loadReset;
	logic isAuto;
	logic condA;
	logic [3:0] condCode;
	logic [15:0] waitSel;
	logic [15:0] rampSel;
	logic [15:0] resetVals [GAINS];
	logic [15:0] laneTarget [GAINS];
	sgss_word_t laneValue [GAINS];
	logic [15:0] rdata_next;
	logic nextSet2;
	logic [15:0] rampStep;

	// Reset values of set A, lane order: speed gain, integral, position gain, filter,
	// model-following gain, model-following compensation, friction.
	assign resetVals[0] = `SGSS_SLG_RESET;
	assign resetVals[1] = `SGSS_SIT_RESET;
	assign resetVals[2] = `SGSS_PLG_RESET;
	assign resetVals[3] = `SGSS_TFT_RESET;
	assign resetVals[4] = `SGSS_MFG_RESET;
	assign resetVals[5] = `SGSS_MFC_RESET;
	assign resetVals[6] = `SGSS_FCG_RESET;

	// Status pins and the select bit come from outside and pass two flip-flops.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			gsel1_reg <= 1'b0;
			gsel2_reg <= 1'b0;
		end else begin
			sync1_reg <= statusPins;
			sync2_reg <= sync1_reg;
			gsel1_reg <= gainSelect;
			gsel2_reg <= gsel1_reg;
		end
	end

	// Configuration and timing registers; times span the full 16-bit range. [R16]
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gainSwitchConfig_reg <= `SGSS_CFG_RESET;
			waitTimeUp_reg <= `SGSS_TIME_RESET;
			waitTimeDown_reg <= `SGSS_TIME_RESET;
			rampTimeUp_reg <= `SGSS_TIME_RESET;
			rampTimeDown_reg <= `SGSS_TIME_RESET;
		end else if (bus.wr) begin
			unique case (bus.addr)
				`SGSS_ADDR_CONFIG: gainSwitchConfig_reg <= bus.wdata;
				`SGSS_ADDR_WAIT_UP: waitTimeUp_reg <= bus.wdata;
				`SGSS_ADDR_WAIT_DOWN: waitTimeDown_reg <= bus.wdata;
				`SGSS_ADDR_RAMP_UP: rampTimeUp_reg <= bus.wdata;
				`SGSS_ADDR_RAMP_DOWN: rampTimeDown_reg <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Both stored gain sets, one register pair per lane. [R03]
	genvar g;
	generate
		for (g = 0; g < GAINS; g++) begin : gLane
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					setA_reg[g] <= resetVals[g];
					setB_reg[g] <= resetVals[g];
				end else if (bus.wr) begin
					if (bus.addr == `SGSS_ADDR_GAIN_A + 5'(g)) begin
						setA_reg[g] <= bus.wdata;
					end
					if (bus.addr == `SGSS_ADDR_GAIN_B + 5'(g)) begin
						setB_reg[g] <= bus.wdata;
					end
				end
			end

			// Lanes 4 and 5 are the model-following pair and follow their own selection.
			if (g == 4 || g == 5) begin : gMf
				assign laneTarget[g] = mfApplied2_reg ? setB_reg[g] : setA_reg[g]; // [R04]
			end else begin : gNorm
				assign laneTarget[g] = nextSet2 ? setB_reg[g] : setA_reg[g];
			end

			sgss_gain_ramp uRamp (
				.clk(clk),
				.rst_b(rst_b),
				.load(loadReset),
				.resetVal(resetVals[g]),
				.start(startRamp),
				.jump(jumpNow || ((g == 4 || g == 5) && !startRamp)),
				.stepEn(stepNow),
				.target(laneTarget[g]),
				.rampLen(rampLen_reg),
				.rampPos(rampStep),
				.value(laneValue[g])
			);
			assign appliedGains[16*g +: 16] = laneValue[g];
		end
	endgenerate

	// One cycle after reset release the lanes load their set A values.
	logic loaded_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b1;
		end
	end
	assign loadReset = !loaded_reg;

	// Method and condition decode. [R01] [R11]
	assign isAuto = gainSwitchConfig_reg[`SGSS_CFG_METHOD_LSB +: 4] == 4'h2;
	assign condCode = gainSwitchConfig_reg[`SGSS_CFG_COND_LSB +: 4];
	always_comb begin
		unique case (condCode)
			4'h0: condA = sync2_reg.posDone;
			4'h1: condA = !sync2_reg.posDone;
			4'h2: condA = sync2_reg.nearPos;
			4'h3: condA = !sync2_reg.nearPos;
			4'h4: condA = sync2_reg.refFilterEmpty && !sync2_reg.posRefInput;
			4'h5: condA = sync2_reg.posRefInput;
			default: condA = 1'b0;
		endcase
	end

	// Required set: manual bit, or condition A in position control, else fixed set. [R07]
	// The speed structure select does not change the switching path. [R15]
	always_comb begin
		if (!isAuto) begin
			wantSet2 = gsel2_reg;
		end else if (sync2_reg.posControl) begin
			wantSet2 = condA; // [R08] [R09] [R10]
		end else begin
			wantSet2 = condCode[0]; // [R12]
		end
	end

	// Wait and ramp times depend on direction. [R09] [R10]
	assign waitSel = wantSet2 ? waitTimeUp_reg : waitTimeDown_reg;
	assign rampSel = wantSet2 ? rampTimeUp_reg : rampTimeDown_reg;

	// Millisecond tick from the control clock.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			msDiv_reg <= 32'h00000000;
		end else if (msDiv_reg == 32'(MS_CYCLES - 1) || state_reg == SGSS_IDLE) begin
			msDiv_reg <= 32'h00000000;
		end else begin
			msDiv_reg <= msDiv_reg + 32'h00000001;
		end
	end
	assign msTick = state_reg != SGSS_IDLE && msDiv_reg == 32'(MS_CYCLES - 1);

	// Manual transitions are immediate; automatic ones wait then ramp.
	logic manualJump;
	assign manualJump = !isAuto && (wantSet2 != target2_reg);
	assign startRamp = isAuto && (wantSet2 != target2_reg); // [R19]
	// The lanes capture their end point in the very cycle the target flag changes.
	assign nextSet2 = (startRamp || manualJump) ? wantSet2 : target2_reg;
	// Each tick moves one step further, so the last tick lands on the new value. [R14]
	assign rampStep = msCount_reg + 16'h0001;
	assign jumpNow = manualJump
		|| (state_reg == SGSS_WAIT && msCount_reg >= waitSel && rampLen_reg == 16'h0000)
		|| (state_reg == SGSS_RAMP && msTick && msCount_reg + 16'h0001 >= rampLen_reg); // [R18]
	assign stepNow = state_reg == SGSS_RAMP && msTick; // [R14]

	// Transition sequencer.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= SGSS_IDLE;
			target2_reg <= 1'b0;
			applied2_reg <= 1'b0;
			msCount_reg <= 16'h0000;
			rampLen_reg <= 16'h0000;
		end else if (manualJump) begin
			target2_reg <= wantSet2;
			applied2_reg <= wantSet2;
			state_reg <= SGSS_IDLE;
		end else if (startRamp) begin
			target2_reg <= wantSet2; // [R19]
			rampLen_reg <= rampSel;
			msCount_reg <= 16'h0000;
			state_reg <= SGSS_WAIT;
		end else begin
			unique case (state_reg)
				SGSS_IDLE: ;
				SGSS_WAIT: begin
					if (msCount_reg >= waitSel) begin // [R13]
						msCount_reg <= 16'h0000;
						if (rampLen_reg == 16'h0000) begin
							applied2_reg <= target2_reg;
							state_reg <= SGSS_IDLE;
						end else begin
							state_reg <= SGSS_RAMP;
						end
					end else if (msTick) begin
						msCount_reg <= msCount_reg + 16'h0001;
					end
				end
				SGSS_RAMP: begin
					if (msTick) begin
						msCount_reg <= msCount_reg + 16'h0001;
						if (msCount_reg + 16'h0001 >= rampLen_reg) begin
							applied2_reg <= target2_reg;
							state_reg <= SGSS_IDLE;
						end
					end
				end
				default: state_reg <= SGSS_IDLE;
			endcase
		end
	end

	// Model-following pair: manual only, and only with no command and motor stopped.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mfApplied2_reg <= 1'b0;
		end else if (isAuto) begin
			mfApplied2_reg <= 1'b0; // [R04]
		end else if (!sync2_reg.cmdBusy && !sync2_reg.moving) begin
			mfApplied2_reg <= gsel2_reg; // [R05]
		end
		// Otherwise the pair holds while the other gains switch. [R06]
	end

	// Active set monitor.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			activeGainSetMonitor <= 2'h1;
		end else begin
			activeGainSetMonitor <= applied2_reg ? 2'h2 : 2'h1; // [R17]
		end
	end

	// Register read mux; unmapped addresses read zero.
	always_comb begin
		rdata_next = 16'h0000;
		if (bus.addr == `SGSS_ADDR_CONFIG) rdata_next = gainSwitchConfig_reg;
		if (bus.addr == `SGSS_ADDR_WAIT_UP) rdata_next = waitTimeUp_reg;
		if (bus.addr == `SGSS_ADDR_WAIT_DOWN) rdata_next = waitTimeDown_reg;
		if (bus.addr == `SGSS_ADDR_RAMP_UP) rdata_next = rampTimeUp_reg;
		if (bus.addr == `SGSS_ADDR_RAMP_DOWN) rdata_next = rampTimeDown_reg;
		if (bus.addr == `SGSS_ADDR_STATUS) begin
			rdata_next = {12'h000, speedStructIp, mfApplied2_reg, state_reg};
		end
		if (bus.addr == `SGSS_ADDR_MONITOR) rdata_next = {14'h0000, activeGainSetMonitor};
		for (int i = 0; i < GAINS; i++) begin
			if (bus.addr == `SGSS_ADDR_GAIN_A + 5'(i)) rdata_next = setA_reg[i];
			if (bus.addr == `SGSS_ADDR_GAIN_B + 5'(i)) rdata_next = setB_reg[i];
		end
	end

	// Read data stand the cycle after the read strobe only.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= bus.rd ? rdata_next : 16'h0000;
		end
	end
endmodule

// ===== logic/sgss_params.svh
// Register offsets, reset values and timing counts of the servo gain set switcher.
`ifndef SGSS_PARAMS_SVH
`define SGSS_PARAMS_SVH
`define SGSS_ADDR_CONFIG 5'h00
`define SGSS_ADDR_GAIN_A 5'h01
`define SGSS_ADDR_GAIN_B 5'h08
`define SGSS_ADDR_WAIT_UP 5'h0F
`define SGSS_ADDR_WAIT_DOWN 5'h10
`define SGSS_ADDR_RAMP_UP 5'h11
`define SGSS_ADDR_RAMP_DOWN 5'h12
`define SGSS_ADDR_STATUS 5'h13
`define SGSS_ADDR_MONITOR 5'h14
`define SGSS_ADDR_APPLIED 5'h18
`define SGSS_CFG_METHOD_LSB 0
`define SGSS_CFG_COND_LSB 4
`define SGSS_CFG_RESET 16'h0000
`define SGSS_TIME_RESET 16'h0000
`define SGSS_SLG_RESET 16'h0190
`define SGSS_SIT_RESET 16'h07D0
`define SGSS_PLG_RESET 16'h0190
`define SGSS_TFT_RESET 16'h0064
`define SGSS_MFG_RESET 16'h01F4
`define SGSS_MFC_RESET 16'h03E8
`define SGSS_FCG_RESET 16'h0064
`define SGSS_STEP_MS 1
`define SGSS_CLK_MHZ 125
`define SGSS_MS_CYCLES (`SGSS_STEP_MS * `SGSS_CLK_MHZ * 1000)
`endif

// ===== logic/sgss_pkg.sv
// Types shared by the servo gain set switcher files.
package sgss_pkg;
	typedef logic [15:0] sgss_word_t;
	typedef enum logic [1:0] {
		SGSS_IDLE = 2'b00,
		SGSS_WAIT = 2'b01,
		SGSS_RAMP = 2'b10
	} sgss_state_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} sgss_bus_s;
	typedef struct packed {
		logic posDone;
		logic nearPos;
		logic refFilterEmpty;
		logic posRefInput;
		logic moving;
		logic cmdBusy;
		logic posControl;
	} sgss_status_s;
endpackage

// ===== logic/sgss_gain_ramp.sv
// One gain lane: linear interpolation between an old and a new value.
`timescale 1ns/1ps
module sgss_gain_ramp
	import sgss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [15:0] resetVal,
	input wire logic start,
	input wire logic jump,
	input wire logic stepEn,
	input wire logic [15:0] target,
	input wire logic [15:0] rampLen,
	input wire logic [15:0] rampPos,
	output sgss_word_t value
);
	logic [15:0] fromReg;
	logic [15:0] toReg;
	logic signed [17:0] span;
	logic signed [34:0] prod;
	logic signed [34:0] quot;
	logic signed [17:0] interp;

	// Interpolated value: from + (to - from) * pos / len.
	always_comb begin
		span = $signed({2'b00, toReg}) - $signed({2'b00, fromReg});
		prod = span * $signed({19'h00000, rampPos});
		quot = (rampLen == 16'h0000) ? 35'sh0 : prod / $signed({19'h00000, rampLen});
		interp = $signed({2'b00, fromReg}) + quot[17:0];
	end

	// Capture the start point from the currently applied value and step it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fromReg <= 16'h0000;
			toReg <= 16'h0000;
			value <= 16'h0000;
		end else if (load) begin
			fromReg <= resetVal;
			toReg <= resetVal;
			value <= resetVal;
		end else if (start) begin
			fromReg <= value;
			toReg <= target;
		end else if (jump) begin
			value <= target;
			fromReg <= target;
		end else if (stepEn) begin
			value <= interp[15:0];
		end
	end
endmodule

// ===== tb/sgss_switcher_asserts.sv
// Concurrent checks on the gain set switcher ports, bound to the design.
`timescale 1ns/1ps
`include "sgss_params.svh"
module sgss_switcher_chk
	import sgss_pkg::*;
#(
	parameter int MS_CYCLES = 4,
	parameter int GAINS = 7
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire sgss_bus_s bus,
	input wire logic [15:0] rdata,
	input wire logic gainSelect,
	input wire logic speedStructIp,
	input wire sgss_status_s statusPins,
	input wire logic [16*GAINS-1:0] appliedGains,
	input wire logic [1:0] activeGainSetMonitor
);
	logic [15:0] shadowCfg_reg;
	logic [15:0] shadowWait_reg;
	logic manual;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Shadow of the configuration word, so the checks know the switching method.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shadowCfg_reg <= 16'h0000;
		end else if (bus.wr && bus.addr == `SGSS_ADDR_CONFIG) begin
			shadowCfg_reg <= bus.wdata;
		end
	end
	// Shadow of the first waiting time for read-back checks.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shadowWait_reg <= 16'h0000;
		end else if (bus.wr && bus.addr == `SGSS_ADDR_WAIT_UP) begin
			shadowWait_reg <= bus.wdata;
		end
	end
	// Any method code other than automatic behaves as manual.
	assign manual = shadowCfg_reg[3:0] != 4'h2;
	monitor_range_a: assert property (
		activeGainSetMonitor == 2'h1 || activeGainSetMonitor == 2'h2) else $error("bad monitor");
	manual_set_two_a: assert property (
		(manual && gainSelect && !bus.wr)[*6] |-> activeGainSetMonitor == 2'h2)
		else $error("manual select 1 ignored");
	manual_set_one_a: assert property (
		(manual && !gainSelect && !bus.wr)[*6] |-> activeGainSetMonitor == 2'h1)
		else $error("manual select 0 ignored");
	follow_auto_hold_a: assert property (
		(!manual && !bus.wr)[*5] |-> $stable(appliedGains[95:64]))
		else $error("follow pair moved in automatic mode");
	follow_moving_hold_a: assert property (
		(manual && !bus.wr && (statusPins.moving || statusPins.cmdBusy))[*6]
		|-> $stable(appliedGains[95:64])) else $error("follow pair moved while busy");
	wait_read_a: assert property (
		bus.rd && bus.addr == `SGSS_ADDR_WAIT_UP |=> rdata == shadowWait_reg)
		else $error("wait time read-back wrong");
	monitor_read_a: assert property (
		bus.rd && bus.addr == `SGSS_ADDR_MONITOR |=>
		rdata == {14'h0000, $past(activeGainSetMonitor)}) else $error("monitor read wrong");
	structure_read_a: assert property (
		(speedStructIp == $past(speedStructIp))[*4] ##0 (bus.rd && bus.addr == `SGSS_ADDR_STATUS)
		|=> rdata[3] == $past(speedStructIp)) else $error("structure bit wrong");
	reset_gains_a: assert property (
		$rose(rst_b) |=> appliedGains[15:0] == `SGSS_SLG_RESET
		&& appliedGains[63:48] == `SGSS_TFT_RESET) else $error("reset gains wrong");
endmodule

bind sgss_switcher sgss_switcher_chk #(.MS_CYCLES(MS_CYCLES), .GAINS(GAINS)) chk (
	.clk(clk),
	.rst_b(rst_b),
	.bus(bus),
	.rdata(rdata),
	.gainSelect(gainSelect),
	.speedStructIp(speedStructIp),
	.statusPins(statusPins),
	.appliedGains(appliedGains),
	.activeGainSetMonitor(activeGainSetMonitor)
);

// ===== tb/sgss_host_model.sv
// Host and motion side model: a lagged gain-select bit and the status levels.
`timescale 1ns/1ps
module sgss_host_model
	import sgss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic selCmd,
	input wire sgss_status_s pinCmd,
	input wire logic [3:0] lag,
	output logic gainSelect,
	output sgss_status_s statusPins
);
	logic [15:0] selPipe_reg;
	// The select bit runs through a delay line so the host can answer promptly or slowly.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			selPipe_reg <= 16'h0000;
			statusPins <= '0;
		end else begin
			selPipe_reg <= {selPipe_reg[14:0], selCmd};
			statusPins <= pinCmd;
		end
	end
	// The chosen tap of the delay line is the option field select bit.
	assign gainSelect = selPipe_reg[lag];
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the servo gain set switcher.
`timescale 1ns/1ps
`include "sgss_params.svh"
module tb_top
	import sgss_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	sgss_bus_s bus = '0;
	logic [15:0] rdata;
	logic selCmd = 1'b0;
	logic speedStructIp = 1'b0;
	sgss_status_s pinCmd = '0;
	logic [3:0] lag = 4'h0;
	logic gainSelect;
	sgss_status_s statusPins;
	logic [111:0] gains;
	logic [1:0] mon;
	logic [15:0] rv;
	int fail_count = 0;
	int compares = 0;
	sgss_switcher #(.MS_CYCLES(4)) dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.gainSelect(gainSelect), .speedStructIp(speedStructIp), .statusPins(statusPins),
		.appliedGains(gains), .activeGainSetMonitor(mon));
	sgss_host_model host (.clk(clk), .rst_b(rst_b), .selCmd(selCmd), .pinCmd(pinCmd),
		.lag(lag), .gainSelect(gainSelect), .statusPins(statusPins));
	// Free-running 125 MHz clock.
	always #4 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		bus <= '0;
		#1 rv = rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic t_reset;
		chk({14'h0000, mon}, 16'h0001);
		chk(gains[15:0], `SGSS_SLG_RESET);
		rd(`SGSS_ADDR_WAIT_UP);
		chk(rv, `SGSS_TIME_RESET);
		rd(5'h1F);
		chk(rv, 16'h0000);
	endtask
	task automatic t_manual;
		lag <= 4'h3;
		wr(`SGSS_ADDR_CONFIG, 16'h0000);
		wr(`SGSS_ADDR_GAIN_B, 16'h0222);
		wr(`SGSS_ADDR_GAIN_B + 5'h04, 16'h0333);
		selCmd <= 1'b1;
		cyc(12);
		chk(gains[15:0], 16'h0222);
		chk(gains[79:64], 16'h0333);
		chk({14'h0000, mon}, 16'h0002);
		pinCmd.moving <= 1'b1;
		selCmd <= 1'b0;
		cyc(12);
		chk(gains[15:0], 16'h0190);
		chk(gains[79:64], 16'h0333);
		pinCmd.moving <= 1'b0;
		cyc(8);
		chk(gains[79:64], `SGSS_MFG_RESET);
	endtask
	task automatic t_auto;
		lag <= 4'h0;
		speedStructIp <= 1'b1;
		pinCmd <= 7'h01;
		wr(`SGSS_ADDR_GAIN_B + 5'h02, 16'h0320);
		wr(`SGSS_ADDR_WAIT_UP, 16'h0002);
		wr(`SGSS_ADDR_RAMP_UP, 16'h0004);
		wr(`SGSS_ADDR_CONFIG, 16'h0002);
		rd(`SGSS_ADDR_STATUS);
		chk({15'h0000, rv[3]}, 16'h0001);
		pinCmd.posDone <= 1'b1;
		cyc(6);
		chk(gains[47:32], 16'h0190);
		cyc(12);
		chk({15'h0000, gains[47:32] > 16'h0190 && gains[47:32] < 16'h0320}, 16'h0001);
		cyc(20);
		chk(gains[47:32], 16'h0320);
		chk(gains[79:64], `SGSS_MFG_RESET);
		chk({14'h0000, mon}, 16'h0002);
		pinCmd.posDone <= 1'b0;
		cyc(8);
		chk(gains[47:32], 16'h0190);
	endtask
	task automatic t_codes;
		logic [6:0] onVec [6] = '{7'h41, 7'h01, 7'h21, 7'h01, 7'h11, 7'h09};
		logic [6:0] offVec [6] = '{7'h01, 7'h41, 7'h01, 7'h21, 7'h01, 7'h01};
		wr(`SGSS_ADDR_WAIT_UP, 16'h0000);
		wr(`SGSS_ADDR_RAMP_UP, 16'h0000);
		for (int c = 0; c < 6; c++) begin
			wr(`SGSS_ADDR_CONFIG, {8'h00, 4'(c), 4'h2});
			pinCmd <= onVec[c];
			cyc(10);
			chk({14'h0000, mon}, 16'h0002);
			pinCmd <= offVec[c];
			cyc(10);
			chk({14'h0000, mon}, 16'h0001);
			pinCmd <= onVec[c] & 7'h7E;
			cyc(10);
			chk({14'h0000, mon}, 16'(c % 2 + 1));
		end
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence: reset, then each scenario in turn.
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_manual;
		t_auto;
		t_codes;
		stop_test;
	end
	// Watchdog well beyond the few hundred cycles the scenarios need.
	initial begin
		#20000;
		fail_count++;
		stop_test;
	end
endmodule
